// >>> emp_defines.vh
`ifndef EMP_DEFINES_VH
`define EMP_DEFINES_VH

// Core clock period and access phase times (least times, rounded up)
`define EMP_CLK_PERIOD_NS 40
`define EMP_SETUP_NS 40
`define EMP_STROBE_NS 120
`define EMP_HOLD_NS 40
`define EMP_SETUP_CYC ((`EMP_SETUP_NS + `EMP_CLK_PERIOD_NS - 1) / `EMP_CLK_PERIOD_NS)
`define EMP_STROBE_CYC ((`EMP_STROBE_NS + `EMP_CLK_PERIOD_NS - 1) / `EMP_CLK_PERIOD_NS)
`define EMP_HOLD_CYC ((`EMP_HOLD_NS + `EMP_CLK_PERIOD_NS - 1) / `EMP_CLK_PERIOD_NS)

// Request queue
`define EMP_FIFO_DEPTH 8
`define EMP_FIFO_AW 3

// Chip-select space field of the word address
`define EMP_SPACE_LSB 26
`define EMP_SPACE_MSB 27

// Memory type per space
`define EMP_TYPE_ASYNC 2'h0
`define EMP_TYPE_SDRAM 2'h1
`define EMP_TYPE_SYNC 2'h2

// Clock strap codes
`define EMP_CLKSEL_EXT 2'h0
`define EMP_CLKSEL_DIV4 2'h1
`define EMP_CLKSEL_DIV6 2'h2
`define EMP_CLKSEL_RSVD 2'h3
`define EMP_CLKSEL_RESET 2'h0
`define EMP_STRAP_SETTLE 2'h3

// Divided output clock ratio codes
`define EMP_RATIO_1 2'h0
`define EMP_RATIO_2 2'h1
`define EMP_RATIO_4 2'h2

// Last count of each half period of the core-derived clocks (half period minus one), in core cycles
`define EMP_DIV4_HALF 2'h1
`define EMP_DIV6_HALF 2'h2

`endif

// >>> emp_fifo.v
`timescale 1ns/10ps
`include "emp_defines.vh"

module emp_fifo #(
  parameter WIDTH = 22,
  parameter DEPTH = `EMP_FIFO_DEPTH,
  parameter AW = `EMP_FIFO_AW
) (
  input wire core_clk,
  input wire reset_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  reg notFull_ff;
  reg empty_ff;
  wire push;
  wire pop;
  reg [AW:0] nxt_count;

  // Ready is kept as its own flop so the port needs no inverter
  assign inReady = notFull_ff;
  assign outValid = ~empty_ff;
  assign outData = mem[rdPtr_ff];
  assign push = inValid & notFull_ff;
  assign pop = outReady & ~empty_ff;

  always @* begin
    nxt_count = count_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop & ~push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      notFull_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      notFull_ff <= (nxt_count != DEPTH[AW:0]);
      empty_ff <= (nxt_count == {(AW+1){1'b0}});
    end
  end
endmodule // emp_fifo

// >>> emp_strobe_ctrl.v
`timescale 1ns/10ps
`include "emp_defines.vh"

// What this block does
// R01: Byte-lane write enables follow the access byte enables and double as the SDRAM data mask.
// R02: A peripheral transfer strobe moves data between two outside peripherals, bus undriven.
// R03: A host asks for the bus on the hold request input and is answered on hold grant out.
// R04: A bus request output shows that the block has accesses pending or in flight.
// R05: Clock straps are caught after reset and pick pin clock, core over four or over six.
// R06: The divided output clock runs at the selected clock over one, two or four.
// R07: The full output clock runs at the selected clock frequency.
// R08: The shared read strobe acts as async read, SDRAM CAS or sync address strobe/read enable.
// R09: For sync spaces the read-enable select picks address strobe (0) or read enable (1).
// R10: The shared output-enable strobe acts as async OE, SDRAM RAS or sync OE.
// R11: The shared write strobe acts as async, SDRAM or sync write enable.
// R12: A FIFO output enable is driven only for sync reads of space three.
// R13: Async memories supply ready on the ready input, sampled during async accesses.
// R14: Exactly one chip select is low per access, chosen by word-address bits 26 to 27 of 26-31.
// R15: Strap code 00 is pin clock, 01 core over four, 10 core over six, 11 reserved.
// R16: A low ready stretches the async strobe phase until ready is seen high.
// R17: While hold is granted the control pins float and no new access starts.
module emp_strobe_ctrl #(
  parameter FIFO_DEPTH = `EMP_FIFO_DEPTH,
  parameter FIFO_AW = `EMP_FIFO_AW
) (
  input wire core_clk,
  input wire reset_n,
  input wire reqValid,
  output wire reqReady,
  input wire reqWrite,
  input wire reqPeriph,
  input wire [31:0] reqWordAddr,
  input wire [1:0] reqByteEn,
  input wire [15:0] reqWrData,
  output reg [15:0] rdData_ff,
  output reg rdValid_ff,
  input wire [7:0] spaceMemType,
  input wire [3:0] readEnSelect,
  input wire [1:0] clkDivRatio,
  input wire [1:0] clkSelStraps,
  input wire extMemClkIn,
  output reg memClkOutFull_ff,
  output reg memClkOutDiv_ff,
  input wire holdReqIn,
  output reg holdGrantOut_ff,
  output reg busReqOut_ff,
  input wire asyncReadyIn,
  output reg [3:0] spaceSelectN_ff,
  output reg [1:0] byteLaneWriteEnN_ff,
  output reg periphDirectXferN_ff,
  output reg sharedReadStrobeN_ff,
  output reg sharedOeStrobeN_ff,
  output reg sharedWriteStrobeN_ff,
  output reg fifoOutputEnN_ff,
  output reg ctrlOe_ff,
  input wire [15:0] memDataIn,
  output reg [15:0] memDataOut_ff,
  output reg memDataOe_ff
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_GRANT = 3'h4;
  localparam integer SETUP_INT = `EMP_SETUP_CYC;
  localparam integer STROBE_INT = `EMP_STROBE_CYC;
  localparam integer HOLD_INT = `EMP_HOLD_CYC;
  // Counts are cut to the phase counter width on purpose
  localparam [3:0] SETUP_CYC = SETUP_INT[3:0];
  localparam [3:0] STROBE_CYC = STROBE_INT[3:0];
  localparam [3:0] HOLD_CYC = HOLD_INT[3:0];
  localparam EW = 22;

  // Queue entry: periph, write, space, byte enables, data
  wire [EW-1:0] qIn;
  wire [EW-1:0] qOut;
  wire qValid;
  wire qPop;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg [EW-1:0] cur_ff;
  reg firstStrobe_ff;

  // Pin synchronisers
  reg holdMeta_ff;
  reg holdSync_ff;
  reg rdyMeta_ff;
  reg rdySync_ff;
  reg extClkMeta_ff;
  reg extClkSync_ff;
  reg [1:0] strapMeta_ff;
  reg [1:0] strapSync_ff;
  reg [15:0] dataMeta_ff;
  reg [15:0] dataSync_ff;

  // Clock generation
  reg [1:0] strapCnt_ff;
  reg strapDone_ff;
  reg [1:0] clkSel_ff;
  reg [1:0] div4Cnt_ff;
  reg div4Lvl_ff;
  reg [1:0] div6Cnt_ff;
  reg div6Lvl_ff;
  reg selLvlPrev_ff;
  reg [1:0] edgeCnt_ff;
  reg selLvl;

  wire curPeriph = cur_ff[21];
  wire curWrite = cur_ff[20];
  wire [1:0] curSpace = cur_ff[19:18];
  wire [1:0] curByteEn = cur_ff[17:16];
  wire [1:0] curType = spaceMemType[{curSpace, 1'b0} +: 2];
  wire curRenSel = readEnSelect[curSpace];
  wire active = (state_ff == ST_SETUP) | (state_ff == ST_STROBE) | (state_ff == ST_HOLD);
  wire strobeDone = (cnt_ff == 4'h0) & ((curType != `EMP_TYPE_ASYNC) | rdySync_ff); // [R13] [R16]

  assign qIn = {reqPeriph, reqWrite, reqWordAddr[`EMP_SPACE_MSB:`EMP_SPACE_LSB], reqByteEn,
                reqWrData};
  assign qPop = (state_ff == ST_IDLE) & ~holdSync_ff; // [R17]

  emp_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData(qIn),
    .outValid(qValid),
    .outReady(qPop),
    .outData(qOut)
  );

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      holdMeta_ff <= 1'b0;
      holdSync_ff <= 1'b0;
      rdyMeta_ff <= 1'b0;
      rdySync_ff <= 1'b0;
      extClkMeta_ff <= 1'b0;
      extClkSync_ff <= 1'b0;
      strapMeta_ff <= 2'h0;
      strapSync_ff <= 2'h0;
      dataMeta_ff <= 16'h0;
      dataSync_ff <= 16'h0;
    end else begin
      holdMeta_ff <= holdReqIn;
      holdSync_ff <= holdMeta_ff;
      rdyMeta_ff <= asyncReadyIn;
      rdySync_ff <= rdyMeta_ff;
      extClkMeta_ff <= extMemClkIn;
      extClkSync_ff <= extClkMeta_ff;
      strapMeta_ff <= clkSelStraps;
      strapSync_ff <= strapMeta_ff;
      dataMeta_ff <= memDataIn;
      dataSync_ff <= dataMeta_ff;
    end
  end

  // Straps are taken once, a few cycles after release, so the pulls have settled
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapCnt_ff <= 2'h0;
      strapDone_ff <= 1'b0;
      clkSel_ff <= `EMP_CLKSEL_RESET;
    end else if (!strapDone_ff) begin
      strapCnt_ff <= strapCnt_ff + 2'h1;
      if (strapCnt_ff == `EMP_STRAP_SETTLE) begin
        strapDone_ff <= 1'b1;
        // Reserved code falls back to the pin clock
        clkSel_ff <= (strapSync_ff == `EMP_CLKSEL_RSVD) ? `EMP_CLKSEL_EXT : // [R05] [R15]
                     strapSync_ff;
      end
    end
  end

  // Pin clock is sampled, so it must stay well below half the core rate
  always @* begin
    case (clkSel_ff)
      `EMP_CLKSEL_DIV4: selLvl = div4Lvl_ff; // [R05] [R15]
      `EMP_CLKSEL_DIV6: selLvl = div6Lvl_ff; // [R05] [R15]
      default: selLvl = extClkSync_ff; // [R05]
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div4Cnt_ff <= 2'h0;
      div4Lvl_ff <= 1'b0;
      div6Cnt_ff <= 2'h0;
      div6Lvl_ff <= 1'b0;
      selLvlPrev_ff <= 1'b0;
      edgeCnt_ff <= 2'h0;
      memClkOutFull_ff <= 1'b0;
      memClkOutDiv_ff <= 1'b0;
    end else begin
      if (div4Cnt_ff == `EMP_DIV4_HALF) begin
        div4Cnt_ff <= 2'h0;
        div4Lvl_ff <= ~div4Lvl_ff;
      end else begin
        div4Cnt_ff <= div4Cnt_ff + 2'h1;
      end
      if (div6Cnt_ff == `EMP_DIV6_HALF) begin
        div6Cnt_ff <= 2'h0;
        div6Lvl_ff <= ~div6Lvl_ff;
      end else begin
        div6Cnt_ff <= div6Cnt_ff + 2'h1;
      end
      selLvlPrev_ff <= selLvl;
      if (selLvl & ~selLvlPrev_ff) begin
        edgeCnt_ff <= edgeCnt_ff + 2'h1;
      end
      memClkOutFull_ff <= selLvl; // [R07]
      case (clkDivRatio)
        `EMP_RATIO_2: memClkOutDiv_ff <= edgeCnt_ff[0]; // [R06]
        `EMP_RATIO_4: memClkOutDiv_ff <= edgeCnt_ff[1]; // [R06]
        default: memClkOutDiv_ff <= selLvl; // [R06]
      endcase
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (holdSync_ff) begin
          nxt_state = ST_GRANT; // [R03] [R17]
        end else if (qValid) begin
          nxt_state = ST_SETUP;
          nxt_cnt = SETUP_CYC - 4'h1;
        end
      end
      ST_SETUP: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_STROBE;
          nxt_cnt = STROBE_CYC - 4'h1;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_STROBE: begin
        if (strobeDone) begin
          nxt_state = ST_HOLD;
          nxt_cnt = HOLD_CYC - 4'h1;
        end else if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_GRANT: begin
        if (!holdSync_ff) begin
          nxt_state = ST_IDLE; // [R17]
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      cur_ff <= {EW{1'b0}};
      firstStrobe_ff <= 1'b0;
      rdData_ff <= 16'h0;
      rdValid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      firstStrobe_ff <= (state_ff == ST_SETUP) & (nxt_state == ST_STROBE);
      if (qPop & qValid) begin
        cur_ff <= qOut;
      end
      rdValid_ff <= 1'b0;
      if ((state_ff == ST_STROBE) & strobeDone & ~curWrite & ~curPeriph) begin
        rdData_ff <= dataSync_ff;
        rdValid_ff <= 1'b1;
      end
    end
  end

  // Pins are registered from the phase state, one cycle behind it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      holdGrantOut_ff <= 1'b0;
      busReqOut_ff <= 1'b0;
      ctrlOe_ff <= 1'b1;
      spaceSelectN_ff <= 4'hf;
      byteLaneWriteEnN_ff <= 2'h3;
      periphDirectXferN_ff <= 1'b1;
      sharedReadStrobeN_ff <= 1'b1;
      sharedOeStrobeN_ff <= 1'b1;
      sharedWriteStrobeN_ff <= 1'b1;
      fifoOutputEnN_ff <= 1'b1;
      memDataOut_ff <= 16'h0;
      memDataOe_ff <= 1'b0;
    end else begin
      holdGrantOut_ff <= (state_ff == ST_GRANT); // [R03]
      ctrlOe_ff <= (state_ff != ST_GRANT); // [R17]
      busReqOut_ff <= qValid | active; // [R04]
      spaceSelectN_ff <= active ? ~(4'h1 << curSpace) : 4'hf; // [R14]
      // Lanes stay active on reads too, so SDRAM sees them as the data mask
      byteLaneWriteEnN_ff <= active ? ~curByteEn : 2'h3; // [R01]
      periphDirectXferN_ff <= ~(active & curPeriph & (state_ff == ST_STROBE)); // [R02]
      memDataOut_ff <= cur_ff[15:0];
      memDataOe_ff <= active & curWrite & ~curPeriph; // [R02]
      sharedReadStrobeN_ff <= 1'b1;
      sharedOeStrobeN_ff <= 1'b1;
      sharedWriteStrobeN_ff <= 1'b1;
      fifoOutputEnN_ff <= 1'b1;
      if (active) begin
        case (curType)
          `EMP_TYPE_SDRAM: begin
            sharedOeStrobeN_ff <= ~(state_ff == ST_SETUP); // [R10]
            sharedReadStrobeN_ff <= ~(state_ff == ST_STROBE); // [R08]
            sharedWriteStrobeN_ff <= ~((state_ff == ST_STROBE) & curWrite); // [R11]
          end
          `EMP_TYPE_SYNC: begin
            if (curRenSel) begin
              sharedReadStrobeN_ff <= ~((state_ff == ST_STROBE) & ~curWrite); // [R08] [R09]
            end else begin
              sharedReadStrobeN_ff <= ~((state_ff == ST_STROBE) & firstStrobe_ff); // [R09]
            end
            sharedOeStrobeN_ff <= ~((state_ff == ST_STROBE) & ~curWrite); // [R10]
            sharedWriteStrobeN_ff <= ~((state_ff == ST_STROBE) & curWrite); // [R11]
            fifoOutputEnN_ff <= ~((state_ff == ST_STROBE) & ~curWrite & // [R12]
                                  (curSpace == 2'h3));
          end
          default: begin
            sharedReadStrobeN_ff <= ~((state_ff == ST_STROBE) & ~curWrite); // [R08]
            sharedOeStrobeN_ff <= ~(~curWrite); // [R10]
            sharedWriteStrobeN_ff <= ~((state_ff == ST_STROBE) & curWrite); // [R11]
          end
        endcase
      end
    end
  end
endmodule // emp_strobe_ctrl

// >>> emp_strobe_ctrl_checker.sv
`timescale 1ns/10ps
module emp_strobe_ctrl_checker (
  input wire core_clk,
  input wire reset_n,
  input wire reqValid,
  input wire reqReady,
  input wire [7:0] spaceMemType,
  input wire [3:0] readEnSelect,
  input wire holdReqIn,
  input wire holdGrantOut_ff,
  input wire busReqOut_ff,
  input wire asyncReadyIn,
  input wire [3:0] spaceSelectN_ff,
  input wire sharedReadStrobeN_ff,
  input wire sharedOeStrobeN_ff,
  input wire sharedWriteStrobeN_ff,
  input wire fifoOutputEnN_ff,
  input wire ctrlOe_ff,
  input wire rdValid_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_ONE_SELECT: assert property ($onehot0(~spaceSelectN_ff))
    else $error("more than one space selected");
  AST_HOLD_FLOAT: assert property (holdGrantOut_ff |->
    !ctrlOe_ff && spaceSelectN_ff == 4'hf)
    else $error("pins driven or access active while hold granted");
  AST_HOLD_GRANT: assert property ($rose(holdReqIn) |-> ##[1:40] holdGrantOut_ff)
    else $error("hold request not granted in time");
  AST_BUS_REQ: assert property (reqValid && reqReady |-> ##[1:2] busReqOut_ff)
    else $error("bus request not raised for queued access");
  AST_FIFO_OE: assert property (!fifoOutputEnN_ff |->
    !spaceSelectN_ff[3] && spaceMemType[7:6] == 2'h2)
    else $error("fifo output enable outside space three sync access");
  // Ready passes two sync flops and the pins lag the state, hence five low samples
  AST_READY_STRETCH: assert property ((!asyncReadyIn) [*5] ##0 (!sharedReadStrobeN_ff &&
    !spaceSelectN_ff[0] && spaceMemType[1:0] == 2'h0) |=> !sharedReadStrobeN_ff)
    else $error("async strobe ended while ready low");
  AST_SYNC_ADS: assert property (!sharedReadStrobeN_ff && !spaceSelectN_ff[2] &&
    spaceMemType[5:4] == 2'h2 && !readEnSelect[2] |=> sharedReadStrobeN_ff)
    else $error("address strobe longer than one cycle");
  AST_SYNC_REN: assert property ($fell(sharedReadStrobeN_ff) && !spaceSelectN_ff[3] &&
    spaceMemType[7:6] == 2'h2 && readEnSelect[3] |-> (!sharedReadStrobeN_ff) [*3])
    else $error("sync read enable shorter than strobe phase");
  AST_SDRAM_RAS: assert property ($fell(sharedOeStrobeN_ff) && !spaceSelectN_ff[1] &&
    spaceMemType[3:2] == 2'h1 |-> ##1 (!sharedReadStrobeN_ff || !sharedWriteStrobeN_ff))
    else $error("row strobe not followed by column or write strobe");
  cover property (rdValid_ff);
  cover property ($rose(holdGrantOut_ff));
  cover property (!fifoOutputEnN_ff);
  cover property (!reqReady);
endmodule // emp_strobe_ctrl_checker

bind emp_strobe_ctrl emp_strobe_ctrl_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .reqValid(reqValid), .reqReady(reqReady), .spaceMemType(spaceMemType),
  .readEnSelect(readEnSelect), .holdReqIn(holdReqIn), .holdGrantOut_ff(holdGrantOut_ff),
  .busReqOut_ff(busReqOut_ff), .asyncReadyIn(asyncReadyIn), .spaceSelectN_ff(spaceSelectN_ff),
  .sharedReadStrobeN_ff(sharedReadStrobeN_ff), .sharedOeStrobeN_ff(sharedOeStrobeN_ff),
  .sharedWriteStrobeN_ff(sharedWriteStrobeN_ff), .fifoOutputEnN_ff(fifoOutputEnN_ff),
  .ctrlOe_ff(ctrlOe_ff), .rdValid_ff(rdValid_ff));

// >>> emp_mem_model.sv
`timescale 1ns/10ps
module emp_mem_model (
  input wire core_clk,
  input wire ctrlOe_ff,
  input wire [3:0] spaceSelectN_ff,
  input wire [1:0] byteLaneWriteEnN_ff,
  input wire sharedWriteStrobeN_ff,
  input wire [15:0] memDataOut_ff,
  input wire memDataOe_ff,
  input wire [7:0] slowCycles,
  output wire asyncReadyIn,
  output wire [15:0] memDataIn
);
  reg [15:0] mem [0:3];
  reg [7:0] waitCnt;
  reg [15:0] lastBus;
  // Floating select pins read high through their pull-ups
  wire sel = ctrlOe_ff && spaceSelectN_ff != 4'hf;
  wire [1:0] sp = {~spaceSelectN_ff[3] | ~spaceSelectN_ff[2],
                   ~spaceSelectN_ff[3] | ~spaceSelectN_ff[1]};
  wire drv = sel && !memDataOe_ff;
  // Ready and read data answer the select within the cycle, as a plain SRAM does
  assign asyncReadyIn = !(sel && waitCnt != 8'h00);
  // Released data bus shows the inverse of its last word
  assign memDataIn = drv ? mem[sp] : ~lastBus;
  initial begin
    waitCnt = 8'h00;
    lastBus = 16'h0000;
    for (int i = 0; i < 4; i++) mem[i] = 16'h0000;
  end
  always @(posedge core_clk) begin
    waitCnt <= !sel ? slowCycles : (waitCnt != 8'h00) ? waitCnt - 8'h01 : waitCnt;
    if (sel && !sharedWriteStrobeN_ff && memDataOe_ff) begin
      if (!byteLaneWriteEnN_ff[0]) mem[sp][7:0] <= memDataOut_ff[7:0];
      if (!byteLaneWriteEnN_ff[1]) mem[sp][15:8] <= memDataOut_ff[15:8];
    end
    if (drv) lastBus <= mem[sp];
  end
endmodule // emp_mem_model

// >>> emp_strobe_ctrl_tb_top.sv
`timescale 1ns/10ps
module emp_strobe_ctrl_tb_top;
  logic core_clk, reset_n, reqValid, reqWrite, reqPeriph, extMemClkIn, holdReqIn;
  logic [31:0] reqWordAddr;
  logic [1:0] reqByteEn, clkDivRatio, clkSelStraps, ek, laneSeen;
  logic [15:0] reqWrData, rdWord;
  logic [7:0] spaceMemType, slowCycles;
  logic [3:0] readEnSelect, selSeen, pSel;
  logic pFull, pDiv;
  wire reqReady, rdValid_ff, memClkOutFull_ff, memClkOutDiv_ff, holdGrantOut_ff, busReqOut_ff;
  wire asyncReadyIn, periphDirectXferN_ff, sharedReadStrobeN_ff, sharedOeStrobeN_ff;
  wire sharedWriteStrobeN_ff, fifoOutputEnN_ff, ctrlOe_ff, memDataOe_ff;
  wire [15:0] rdData_ff, memDataIn, memDataOut_ff;
  wire [3:0] spaceSelectN_ff;
  wire [1:0] byteLaneWriteEnN_ff;
  int failures, comparisons, fullTg, divTg, accCnt, rdLow, fifoLow, pdxLow, oeHigh, a, b, e, n;
  int oeLow;

  emp_strobe_ctrl uut (.core_clk, .reset_n, .reqValid, .reqReady, .reqWrite, .reqPeriph,
    .reqWordAddr, .reqByteEn, .reqWrData, .rdData_ff, .rdValid_ff, .spaceMemType, .readEnSelect,
    .clkDivRatio, .clkSelStraps, .extMemClkIn, .memClkOutFull_ff, .memClkOutDiv_ff, .holdReqIn,
    .holdGrantOut_ff, .busReqOut_ff, .asyncReadyIn, .spaceSelectN_ff, .byteLaneWriteEnN_ff,
    .periphDirectXferN_ff, .sharedReadStrobeN_ff, .sharedOeStrobeN_ff, .sharedWriteStrobeN_ff,
    .fifoOutputEnN_ff, .ctrlOe_ff, .memDataIn, .memDataOut_ff, .memDataOe_ff);
  emp_mem_model mem (.core_clk, .ctrlOe_ff, .spaceSelectN_ff, .byteLaneWriteEnN_ff,
    .sharedWriteStrobeN_ff, .memDataOut_ff, .memDataOe_ff, .slowCycles, .asyncReadyIn, .memDataIn);

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ek <= ek + 2'h1;
    if (ek == 2'h3) extMemClkIn <= ~extMemClkIn;
    pFull <= memClkOutFull_ff;
    pDiv <= memClkOutDiv_ff;
    pSel <= spaceSelectN_ff;
    fullTg += (pFull !== memClkOutFull_ff);
    divTg += (pDiv !== memClkOutDiv_ff);
    accCnt += (pSel == 4'hf && spaceSelectN_ff != 4'hf);
    if (spaceSelectN_ff != 4'hf) selSeen |= ~spaceSelectN_ff;
    if (spaceSelectN_ff != 4'hf) laneSeen |= ~byteLaneWriteEnN_ff;
    rdLow += !sharedReadStrobeN_ff;
    oeLow += !sharedOeStrobeN_ff;
    fifoLow += !fifoOutputEnN_ff;
    pdxLow += !periphDirectXferN_ff;
    oeHigh += memDataOe_ff;
    if (rdValid_ff === 1'b1) rdWord = rdData_ff;
  end

  task chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task finish_test;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task doReset(input [1:0] st);
    @(posedge core_clk);
    reset_n <= 0;
    clkSelStraps <= st;
    repeat (6) @(posedge core_clk);
    reset_n <= 1;
    repeat (20) @(posedge core_clk);
  endtask
  task push(input bit w, p, input [1:0] sp, be, input [15:0] d);
    reqValid <= 1;
    reqWrite <= w;
    reqPeriph <= p;
    reqWordAddr <= {4'h0, sp, 26'h0};
    reqByteEn <= be;
    reqWrData <= d;
    @(negedge core_clk);
    while (reqReady !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
  endtask
  task waitIdle(input int lim);
    int k;
    k = 0;
    repeat (2) @(negedge core_clk);
    while ((busReqOut_ff !== 1'b0 || spaceSelectN_ff !== 4'hf) && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    chk(k < lim, "access did not finish");
    @(posedge core_clk);
  endtask
  task run(input bit w, p, input [1:0] sp, be, input [15:0] d);
    push(w, p, sp, be, d);
    reqValid <= 0;
    @(negedge core_clk);
    {selSeen, laneSeen, rdLow, fifoLow, pdxLow, oeHigh, oeLow} = '0;
    waitIdle(80);
  endtask

  initial begin
    {reset_n, reqValid, reqWrite, reqPeriph, extMemClkIn, holdReqIn, ek} = '0;
    {reqWordAddr, reqByteEn, reqWrData, clkDivRatio, clkSelStraps, slowCycles} = '0;
    {pFull, pDiv, pSel} = 6'h0f;
    spaceMemType = 8'ha4;
    readEnSelect = 4'h8;
    doReset(2'h0);
    @(negedge core_clk);
    chk(spaceSelectN_ff === 4'hf && byteLaneWriteEnN_ff === 2'h3 &&
        ctrlOe_ff === 1'b1, "idle pins");
    chk(holdGrantOut_ff === 1'b0 && busReqOut_ff === 1'b0 &&
        reqReady === 1'b1, "idle flags");
    // Strap code 3 is reserved and must fall back to the pin clock
    for (int s = 0; s < 4; s++) begin
      doReset(s[1:0]);
      for (int r = 0; r < 4; r++) begin
        @(posedge core_clk);
        clkDivRatio <= r[1:0];
        repeat (8) @(negedge core_clk);
        a = fullTg;
        b = divTg;
        repeat (96) @(negedge core_clk);
        a = fullTg - a;
        // Ratio code 3 runs undivided
        b = (divTg - b) << (r % 3);
        e = (s == 1) ? 48 : (s == 2) ? 32 : 24;
        chk(a >= e - 1 && a <= e + 1, "full clock rate");
        chk(b >= a - (2 << (r % 3)) && b <= a + (2 << (r % 3)), "divided clock rate");
      end
    end
    $display("test clocks done");
    for (int sp = 0; sp < 4; sp++) begin
      run(1, 0, sp[1:0], 2'h3, 16'h1230 + sp[15:0]);
      chk(selSeen === 4'h1 << sp && oeHigh > 0, "write select");
      run(0, 0, sp[1:0], 2'h3, 16'h0000);
      chk(rdWord === 16'h1230 + sp[15:0] && laneSeen === 2'h3, "read back");
      chk((sp == 3) ? fifoLow > 0 : fifoLow == 0, "fifo enable");
      chk(oeLow == ((sp == 0) ? 5 : (sp == 1) ? 1 : 3), "output enable strobe");
      if (sp > 1) chk(rdLow == ((sp == 3) ? 3 : 1), "sync read strobe");
    end
    run(1, 0, 2'h0, 2'h1, 16'habcd);
    chk(laneSeen === 2'h1, "lane enable");
    run(0, 0, 2'h0, 2'h3, 16'h0000);
    chk(rdWord === 16'h12cd, "partial write");
    run(1, 1, 2'h1, 2'h3, 16'h5555);
    chk(pdxLow > 0 && oeHigh == 0, "peripheral transfer");
    slowCycles <= 8'h08;
    run(0, 0, 2'h0, 2'h3, 16'h0000);
    chk(rdLow >= 8 && rdWord === 16'h12cd, "ready stretch");
    $display("test accesses done");
    slowCycles <= 8'h00;
    holdReqIn <= 1;
    n = 0;
    while (holdGrantOut_ff !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(holdGrantOut_ff === 1'b1 && ctrlOe_ff === 1'b0, "hold grant");
    @(posedge core_clk);
    b = accCnt;
    for (int i = 0; i < 8; i++) push(1, 0, 2'h0, 2'h3, i[15:0]);
    reqWrData <= 16'h0009;
    repeat (3) @(posedge core_clk);
    reqValid <= 0;
    @(negedge core_clk);
    chk(reqReady === 1'b0 && busReqOut_ff === 1'b1 && accCnt == b, "queue held");
    @(posedge core_clk);
    slowCycles <= 8'h03;
    holdReqIn <= 0;
    waitIdle(400);
    chk(accCnt == b + 8 && holdGrantOut_ff === 1'b0, "queue drained");
    run(0, 0, 2'h0, 2'h3, 16'h0000);
    chk(rdWord === 16'h0007, "refused request");
    $display("test hold done");
    finish_test;
  end
  initial begin
    #800000;
    failures++;
    finish_test;
  end
endmodule // emp_strobe_ctrl_tb_top
